/* verilog/scs_defs.vh */
// Constants of the sequential code selector: character codes and mode encodings.
`ifndef SCS_DEFS_VH
`define SCS_DEFS_VH
`define SCS_CODE_W 5
`define SCS_CHR_CR 5'h02
`define SCS_CHR_LF 5'h08
`define SCS_CHR_LTRS 5'h1f
`define SCS_CHR_FIGS 5'h1b
`define SCS_MODE_LETTERS 2'h0
`define SCS_MODE_FIGURES 2'h1
`define SCS_MODE_SILENT 2'h2
`define SCS_MODE_RESET 2'h0
`endif

/* verilog/scs_selector.v */
// Sequential code selector: mode tracking, selection gate and chained character matchers.
// Behaviour
// - Three modes exist: letters, figures and silent monitor.
// - Letters mode outputs characters as letters and lower-case functions.
// - After figures shift, characters are interpreted as symbols and numerals.
// - Silent monitor suppresses output while matching continues on every character.
// - Conditioning sequence opens the gate; gated calls then become recognisable.
// - Deconditioning sequence closes the gate; traffic then triggers no calls.
// - A call marked never-in-traffic is recognised without the gate.
// - A recognised call drives a changeover output with normally-open and normally-closed paths.
// - Only consecutive characters in exact order trigger a sequence.
// - Default sequence is carriage return, line feed, letters shift.
// - Each character has its own stage, chained in adjacent order.
// - Non-final stages match, latch and enable next; final drives function.
// - First stage matches carriage return alone; second stage stays idle.
// - Line feed without preceding carriage return is blocked at stage two.
// - Each latch clears on the next character strobe, enabling one character.
// - Character elements arrive with element 1 first, element 5 last.
// - Element value 1 means marking, 0 means spacing.
// - A wrong character after stage one clears it and returns to idle.
`timescale 1ns/1ps
`include "scs_defs.vh"
module scs_selector #(
   parameter CALL_LEN = 3,
   parameter COND_LEN = 3,
   parameter DCND_LEN = 2,
   parameter [CALL_LEN*5-1:0] CALL_SEQ = {`SCS_CHR_LTRS, `SCS_CHR_LF, `SCS_CHR_CR},
   parameter [COND_LEN*5-1:0] COND_SEQ = {`SCS_CHR_LTRS, `SCS_CHR_CR, `SCS_CHR_CR},
   parameter [DCND_LEN*5-1:0] DCND_SEQ = {`SCS_CHR_LTRS, `SCS_CHR_FIGS},
   parameter CALL_UNGATED = 1'b0,
   parameter CALL_HOLD = 1'b0
) (
   input wire clk,
   input wire arst_n,
   input wire [4:0] rx_char,
   input wire rx_valid,
   input wire silent_monitor_mode,
   output reg [4:0] out_char_ff,
   output reg out_valid_ff,
   output reg out_figures_ff,
   output reg [1:0] mode_ff,
   output reg gate_open_ff,
   output reg code_directing_call_ff,
   output wire call_no_path,
   output wire call_nc_path
);

   reg [CALL_LEN-2:0] call_lat_ff;
   reg [COND_LEN-2:0] cond_lat_ff;
   reg [DCND_LEN-2:0] dcnd_lat_ff;
   reg sil_meta_ff;
   reg sil_sync_ff;
   wire [CALL_LEN-1:0] call_hit;
   wire [COND_LEN-1:0] cond_hit;
   wire [DCND_LEN-1:0] dcnd_hit;
   wire call_fire;
   wire cond_fire;
   wire dcnd_fire;
   reg [1:0] nxt_mode;
   reg nxt_call;

   // Stage matching is only done on a strobed character; element 1 is bit 0, 1 is mark.
   function stage_hit;
      input [4:0] rx;
      input [4:0] code;
      input enabled;
      begin
         stage_hit = enabled && (rx == code);
      end
   endfunction

   genvar i;
   generate
      for (i = 0; i < CALL_LEN; i = i + 1) begin : g_call
         if (i == 0) begin : g_first
            assign call_hit[i] = rx_valid && stage_hit(rx_char, CALL_SEQ[4:0], 1'b1);
         end else begin : g_next
            assign call_hit[i] = rx_valid &&
               stage_hit(rx_char, CALL_SEQ[i*5+4:i*5], call_lat_ff[i-1]);
         end
      end
      for (i = 0; i < COND_LEN; i = i + 1) begin : g_cond
         if (i == 0) begin : g_first
            assign cond_hit[i] = rx_valid && stage_hit(rx_char, COND_SEQ[4:0], 1'b1);
         end else begin : g_next
            assign cond_hit[i] = rx_valid &&
               stage_hit(rx_char, COND_SEQ[i*5+4:i*5], cond_lat_ff[i-1]);
         end
      end
      for (i = 0; i < DCND_LEN; i = i + 1) begin : g_dcnd
         if (i == 0) begin : g_first
            assign dcnd_hit[i] = rx_valid && stage_hit(rx_char, DCND_SEQ[4:0], 1'b1);
         end else begin : g_next
            assign dcnd_hit[i] = rx_valid &&
               stage_hit(rx_char, DCND_SEQ[i*5+4:i*5], dcnd_lat_ff[i-1]);
         end
      end
   endgenerate

   // The final stage has no latch and acts directly.
   assign call_fire = call_hit[CALL_LEN-1] && (gate_open_ff || CALL_UNGATED);
   assign cond_fire = cond_hit[COND_LEN-1];
   assign dcnd_fire = dcnd_hit[DCND_LEN-1];

   // Non-final latches reload on every strobe, so each lasts one character only.
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         call_lat_ff <= {(CALL_LEN-1){1'b0}};
         cond_lat_ff <= {(COND_LEN-1){1'b0}};
         dcnd_lat_ff <= {(DCND_LEN-1){1'b0}};
      end else if (rx_valid) begin
         call_lat_ff <= call_hit[CALL_LEN-2:0];
         cond_lat_ff <= cond_hit[COND_LEN-2:0];
         dcnd_lat_ff <= dcnd_hit[DCND_LEN-2:0];
      end
   end

   // The silent monitor select comes from a pin and passes two flip-flops.
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         sil_meta_ff <= 1'b0;
         sil_sync_ff <= 1'b0;
      end else begin
         sil_meta_ff <= silent_monitor_mode;
         sil_sync_ff <= sil_meta_ff;
      end
   end

   // Selection gate.
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         gate_open_ff <= 1'b0;
      end else if (dcnd_fire) begin
         gate_open_ff <= 1'b0;
      end else if (cond_fire) begin
         gate_open_ff <= 1'b1;
      end
   end

   // Changeover contact: a pulse per call, or a toggle when holding.
   always @* begin
      nxt_call = 1'b0;
      if (CALL_HOLD) begin
         nxt_call = code_directing_call_ff ^ call_fire;
      end else begin
         nxt_call = call_fire;
      end
   end

   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         code_directing_call_ff <= 1'b0;
      end else begin
         code_directing_call_ff <= nxt_call;
      end
   end

   assign call_no_path = code_directing_call_ff;
   assign call_nc_path = ~code_directing_call_ff;

   // Mode machine; silent monitor overrides the shift state.
   always @* begin
      nxt_mode = mode_ff;
      case (mode_ff)
         `SCS_MODE_LETTERS: begin
            if (sil_sync_ff) begin
               nxt_mode = `SCS_MODE_SILENT;
            end else if (rx_valid && rx_char == `SCS_CHR_FIGS) begin
               nxt_mode = `SCS_MODE_FIGURES;
            end
         end
         `SCS_MODE_FIGURES: begin
            if (sil_sync_ff) begin
               nxt_mode = `SCS_MODE_SILENT;
            end else if (rx_valid && rx_char == `SCS_CHR_LTRS) begin
               nxt_mode = `SCS_MODE_LETTERS;
            end
         end
         `SCS_MODE_SILENT: begin
            if (!sil_sync_ff) begin
               nxt_mode = `SCS_MODE_LETTERS;
            end
         end
         default: begin
            nxt_mode = `SCS_MODE_RESET;
         end
      endcase
   end

   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         mode_ff <= `SCS_MODE_RESET;
      end else begin
         mode_ff <= nxt_mode;
      end
   end

   // Character output, tagged with the case it is to be read in.
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         out_char_ff <= 5'h00;
         out_valid_ff <= 1'b0;
         out_figures_ff <= 1'b0;
      end else begin
         out_valid_ff <= rx_valid && (mode_ff != `SCS_MODE_SILENT) && !sil_sync_ff;
         if (rx_valid) begin
            out_char_ff <= rx_char;
            out_figures_ff <= (mode_ff == `SCS_MODE_FIGURES);
         end
      end
   end

endmodule // scs_selector

/* verification/scs_rx_model.sv */
// Receiver-side model: presents whole characters with a one-cycle strobe.
`timescale 1ns/1ps
module scs_rx_model (
   input clk,
   output logic [4:0] rx_char,
   output logic rx_valid
);
   initial begin
      rx_char = 5'h00;
      rx_valid = 1'b0;
   end
   // Element 1 lands in bit 0 and a one is marking.
   task send(input logic [4:0] c);
      rx_char <= c;
      rx_valid <= 1'b1;
      @(posedge clk);
   endtask
   // Released data shows the inverse of the last character.
   task stop();
      rx_valid <= 1'b0;
      rx_char <= ~rx_char;
   endtask
endmodule // scs_rx_model

/* verification/scs_selector_props.sv */
// Concurrent checks on the selector ports.
`timescale 1ns/1ps
module scs_selector_props (
   input clk,
   input arst_n,
   input [4:0] rx_char,
   input rx_valid,
   input silent_monitor_mode,
   input [4:0] out_char_ff,
   input out_valid_ff,
   input [1:0] mode_ff,
   input gate_open_ff,
   input code_directing_call_ff,
   input call_no_path,
   input call_nc_path
);
   wire talk = !silent_monitor_mode && mode_ff != 2'h2;
   wire cr = rx_valid && rx_char == 5'h02;
   wire lf = rx_valid && rx_char == 5'h08;
   wire lt = rx_valid && rx_char == 5'h1f;
   wire call = code_directing_call_ff;
   default clocking @(posedge clk); endclocking
   default disable iff (!arst_n);
   sequence s_cond; cr ##1 cr ##1 lt; endsequence
   sequence s_call; cr ##1 lf ##1 lt; endsequence
   property p_out; rx_valid && talk |=> out_valid_ff && out_char_ff == $past(rx_char);
   endproperty
   property p_sil; rx_valid && silent_monitor_mode && mode_ff == 2'h2 |=> !out_valid_ff;
   endproperty
   property p_figs; rx_valid && rx_char == 5'h1b && talk |=> mode_ff == 2'h1; endproperty
   property p_cond; s_cond |=> gate_open_ff; endproperty
   property p_call; gate_open_ff ##0 s_call |=> call; endproperty
   property p_shut; !gate_open_ff |=> !call; endproperty
   property p_brk; cr ##1 rx_valid && !lf ##1 lt |=> !call; endproperty
   property p_one; call |=> !call; endproperty
   property p_path; call_no_path == call && call_nc_path == !call; endproperty
   a_out: assert property (p_out) else $error("char not passed");
   a_sil: assert property (p_sil) else $error("silent output");
   a_figs: assert property (p_figs) else $error("no figures");
   a_cond: assert property (p_cond) else $error("gate shut");
   a_call: assert property (p_call) else $error("call missed");
   a_shut: assert property (p_shut) else $error("call while shut");
   a_brk: assert property (p_brk) else $error("broken call");
   a_one: assert property (p_one) else $error("long call");
   a_path: assert property (p_path) else $error("bad paths");
endmodule // scs_selector_props

/* verification/scs_selector_tb.sv */
// Self-checking bench for the sequential code selector.
`timescale 1ns/1ps
module scs_selector_tb;
   logic clk = 1'b0;
   logic arst_n = 1'b0;
   logic silent = 1'b0;
   logic g = 1'b0;
   logic [4:0] c;
   int err_total = 0;
   int checked = 0;
   wire [4:0] rx_char, out_char_ff;
   wire rx_valid, out_valid_ff, gate_open_ff, call_ff, figs_ff, nc_path;
   wire [1:0] mode_ff;
   always #20 clk = ~clk;
   scs_rx_model RX (.clk(clk), .rx_char(rx_char), .rx_valid(rx_valid));
   scs_selector DUT (.clk(clk), .arst_n(arst_n), .rx_char(rx_char), .rx_valid(rx_valid),
      .silent_monitor_mode(silent), .out_char_ff(out_char_ff), .out_valid_ff(out_valid_ff),
      .out_figures_ff(figs_ff), .mode_ff(mode_ff), .gate_open_ff(gate_open_ff),
      .code_directing_call_ff(call_ff), .call_no_path(), .call_nc_path(nc_path));
   task chk(input logic [4:0] got, input logic [4:0] exp);
      checked++;
      if (got !== exp) begin
         err_total++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   function logic f_call(input logic [4:0] q[$]);
      int n;
      n = q.size();
      return g && n > 2 && q[n-3] == 5'h02 && q[n-2] == 5'h08 && q[n-1] == 5'h1f;
   endfunction
   task run(input logic [4:0] q[$]);
      foreach (q[i]) RX.send(q[i]);
      RX.stop();
      #1;
      chk(call_ff, f_call(q));
      chk(out_valid_ff, !silent);
      if (!silent) chk(out_char_ff, q[q.size()-1]);
      @(posedge clk);
   endtask
   task finish_test();
      $display("checks %0d errors %0d", checked, err_total);
      if (err_total == 0 && checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   initial begin
      void'($urandom(63858));
      repeat (16) @(posedge clk);
      arst_n <= 1'b1;
      @(posedge clk);
      chk(gate_open_ff, 1'b0);
      chk(mode_ff, 2'h0);
      chk(nc_path, 1'b1);
      run('{5'h02, 5'h08, 5'h1f});
      run('{5'h02, 5'h02, 5'h1f});
      g = 1'b1;
      chk(gate_open_ff, 1'b1);
      run('{5'h02, 5'h08, 5'h1f});
      for (int i = 0; i < 12; i++) begin
         c = 5'($urandom);
         if (c == 5'h08 || c == 5'h1b) c = 5'h04;
         run('{5'h02, c, 5'h1f});
         run('{c, 5'h08, 5'h1f});
      end
      run('{5'h08, 5'h02, 5'h1f});
      silent <= 1'b1;
      repeat (4) @(posedge clk);
      chk(mode_ff, 2'h2);
      run('{5'h02, 5'h08, 5'h1f});
      silent <= 1'b0;
      repeat (4) @(posedge clk);
      run('{5'h1b});
      chk(mode_ff, 2'h1);
      g = 1'b0;
      run('{5'h1f});
      chk(mode_ff, 2'h0);
      chk(figs_ff, 1'b1);
      chk(gate_open_ff, 1'b0);
      run('{5'h02, 5'h08, 5'h1f});
      chk(figs_ff, 1'b0);
      finish_test();
   end
   initial begin
      #100000;
      err_total++;
      $display("[ERR] %0t watchdog expired", $time);
      finish_test();
   end
endmodule // scs_selector_tb
bind scs_selector scs_selector_props PROPS (.*);
